// *** fst_pkg.sv ***
// Constants, types and helper functions of the fail-safe timer configuration block
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
package fst_pkg;

	// -------------------------------------------------------------------------
	// Bus and register map
	// -------------------------------------------------------------------------
	localparam int          ADDR_W          = 12;
	localparam int          DATA_W          = 32;
	localparam logic [7:0]  IDX_WD_INIT     = 8'hCA;
	localparam logic [7:0]  IDX_SHORT_TH    = 8'hCB;
	localparam logic [7:0]  IDX_CRC_REF     = 8'hCF;
	localparam logic [7:0]  IDX_CONF_TIMERS = 8'h40;
	localparam logic [7:0]  IDX_CONF_SHORT  = 8'h41;
	localparam logic [7:0]  IDX_CTRL        = 8'h42;
	localparam logic [7:0]  IDX_STATUS      = 8'h43;

	localparam logic [7:0]  WD_INIT_RESET   = 8'h00;
	localparam logic [7:0]  SHORT_TH_RESET  = 8'h00;

	// Field positions
	localparam int          WD_CODE_LSB     = 4;
	localparam int          INIT_CODE_LSB   = 0;
	localparam int          CTRL_KICK_BIT   = 0;
	localparam int          CTRL_RELOAD_BIT = 1;
	localparam int          CTRL_EXIT_BIT   = 2;
	localparam int          STAT_FS_BIT     = 0;
	localparam int          STAT_INIT_BIT   = 1;
	localparam int          STAT_CRC_BIT    = 2;

	// Codes
	localparam logic [3:0]  WD_DISABLED     = 4'h0;
	localparam logic [3:0]  WD_DIRECT       = 4'hC;
	localparam logic [7:0]  CRC_POLY        = 8'h07;
	localparam logic [7:0]  CRC_SEED        = 8'h00;

	// -------------------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------------------
	localparam int          CLK_PERIOD_NS   = 8;
	localparam int          NS_PER_US       = 1000;
	localparam int          CYC_PER_US      = NS_PER_US / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_LOAD,
		ST_INIT,
		ST_NORMAL,
		ST_FAILSAFE
	} fst_state_e;

	typedef struct packed {
		logic [3:0] wd_code;
		logic [3:0] init_code;
		logic [7:0] short_th;
	} fst_conf_s;

	typedef struct packed {
		logic failsafe;
		logic init_done;
		logic crc_fault;
	} fst_status_s;

	// Watchdog timeout in microseconds; 0 for disabled and direct codes
	function automatic int wd_time_us(input logic [3:0] code);
		case (code)
			4'h1: wd_time_us = 200;
			4'h2: wd_time_us = 500;
			4'h3: wd_time_us = 1000;
			4'h4: wd_time_us = 2000;
			4'h5: wd_time_us = 5000;
			4'h6: wd_time_us = 10000;
			4'h7: wd_time_us = 20000;
			4'h8: wd_time_us = 50000;
			4'h9: wd_time_us = 100000;
			4'hA: wd_time_us = 200000;
			4'hB: wd_time_us = 500000;
			default: wd_time_us = 0;
		endcase
	endfunction : wd_time_us

	// Initialization delay in microseconds
	function automatic int init_time_us(input logic [3:0] code);
		case (code)
			4'h0: init_time_us = 0;
			4'h1: init_time_us = 50000;
			4'h2: init_time_us = 20000;
			4'h3: init_time_us = 10000;
			4'h4: init_time_us = 5000;
			4'h5: init_time_us = 2000;
			4'h6: init_time_us = 1000;
			4'h7: init_time_us = 500;
			4'h8: init_time_us = 200;
			4'h9: init_time_us = 100;
			default: init_time_us = 50;
		endcase
	endfunction : init_time_us

	// One byte through an MSB-first CRC-8
	function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		crc8_byte = c;
	endfunction : crc8_byte

endpackage : fst_pkg

// *** fst_timer.sv ***
// Loadable down-counter that pulses once when its delay has run out
`timescale 1ns/1ps
module fst_timer
	import fst_pkg::*;
(
	input  wire logic        pclk,     // Bus clock
	input  wire logic        presetn,  // Async reset, active low
	input  wire logic        start,    // Load and run
	input  wire logic        abort,    // Stop without expiry
	input  wire logic [31:0] load_val, // Delay in cycles
	output logic             expired,  // One-cycle expiry pulse
	output logic             running   // Counting
);

	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic        run_reg;
	logic        run_next;
	logic        exp_reg;
	logic        exp_next;

	always_comb begin
		cnt_next = cnt_reg;
		run_next = run_reg;
		exp_next = 1'b0;
		if (abort) begin
			run_next = 1'b0;
		end else if (start) begin
			if (load_val == 32'h0000_0000) begin
				exp_next = 1'b1;
				run_next = 1'b0;
			end else begin
				cnt_next = load_val;
				run_next = 1'b1;
			end
		end else if (run_reg) begin
			if (cnt_reg == 32'h0000_0001) begin
				exp_next = 1'b1;
				run_next = 1'b0;
			end else begin
				cnt_next = cnt_reg - 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= 32'h0000_0000;
			run_reg <= 1'b0;
			exp_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			run_reg <= run_next;
			exp_reg <= exp_next;
		end
	end

	assign expired = exp_reg;
	assign running = run_reg;

	property p_count_down;
		@(posedge pclk) disable iff (!presetn)
		run_reg && !start && !abort && cnt_reg > 32'h0000_0001
			|=> run_reg && cnt_reg == $past(cnt_reg) - 32'h0000_0001;
	endproperty
	a_count_down: assert property (p_count_down) else $error("timer did not count down");

endmodule : fst_timer

// *** fst_crc_check.sv ***
// Integrity check of the stored configuration bytes against their CRC reference
`timescale 1ns/1ps
module fst_crc_check
	import fst_pkg::*;
(
	input  wire logic       pclk,      // Bus clock
	input  wire logic       presetn,   // Async reset, active low
	input  wire logic [7:0] nv_timers, // Stored timer byte
	input  wire logic [7:0] nv_short,  // Stored threshold byte
	input  wire logic [7:0] nv_ref,    // Stored CRC reference
	output logic            crc_fault  // Mismatch, level
);

	logic [7:0] calc;
	logic       fault_reg;
	logic       fault_next;

	always_comb begin
		calc       = crc8_byte(crc8_byte(CRC_SEED, nv_timers), nv_short);
		fault_next = (calc != nv_ref);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_reg <= 1'b0;
		end else begin
			fault_reg <= fault_next;
		end
	end

	assign crc_fault = fault_reg;

	property p_fault_follows;
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) && $stable(nv_timers) && $stable(nv_short) && $stable(nv_ref)
			|-> crc_fault == (crc8_byte(crc8_byte(CRC_SEED, nv_timers), nv_short) != nv_ref);
	endproperty
	a_fault_follows: assert property (p_fault_follows) else $error("crc fault flag wrong");

endmodule : fst_crc_check

// *** fst_failsafe_cfg.sv ***
// Stored timer configuration, init/watchdog sequencing and APB register slave
`timescale 1ns/1ps
module fst_failsafe_cfg
	import fst_pkg::*;
#(
	parameter int         CYCLES_PER_US = CYC_PER_US, // Shorten long delays in simulation
	parameter logic [7:0] CRC_REF_RESET = 8'h5A       // Arbitrary value
)(
	input  wire logic              pclk,          // Bus clock, 125 MHz
	input  wire logic              presetn,       // Async reset, active low
	input  wire logic              psel,          // APB select
	input  wire logic              penable,       // APB enable
	input  wire logic              pwrite,        // APB direction
	input  wire logic [ADDR_W-1:0] paddr,         // APB byte address
	input  wire logic [DATA_W-1:0] pwdata,        // APB write data
	output logic      [DATA_W-1:0] prdata,        // APB read data
	output logic                   pready,        // APB ready
	output logic                   pslverr,       // APB error
	input  wire logic              link_rx,       // Transceiver receive pin
	output fst_conf_s              conf,          // Working configuration
	output fst_status_s            status         // Fail-safe, init, CRC state
);

	// -------------------------------------------------------------------------
	// Address decode
	// -------------------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a == {2'b00, idx, 2'b00});
	endfunction : hit

	logic wr_en;
	logic rd_setup;
	logic mapped;

	always_comb begin
		wr_en    = psel && penable && pwrite;
		rd_setup = psel && !penable && !pwrite;
		mapped   = hit(paddr, IDX_WD_INIT) || hit(paddr, IDX_SHORT_TH) ||
		           hit(paddr, IDX_CRC_REF) || hit(paddr, IDX_CONF_TIMERS) ||
		           hit(paddr, IDX_CONF_SHORT) || hit(paddr, IDX_CTRL) ||
		           hit(paddr, IDX_STATUS);
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// -------------------------------------------------------------------------
	// Link activity
	// -------------------------------------------------------------------------
	// Any edge on the receive pin counts as controller traffic
	logic rx_meta_reg;
	logic rx_sync_reg;
	logic rx_prev_reg;
	logic link_act;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_meta_reg <= link_rx;
			rx_sync_reg <= rx_meta_reg;
			rx_prev_reg <= rx_sync_reg;
		end
	end

	assign link_act = rx_sync_reg ^ rx_prev_reg;

	// -------------------------------------------------------------------------
	// Stored bytes and working configuration
	// -------------------------------------------------------------------------
	logic [7:0] nv_timers_reg;
	logic [7:0] nv_timers_next;
	logic [7:0] nv_short_reg;
	logic [7:0] nv_short_next;
	logic [7:0] nv_crc_reg;
	logic [7:0] nv_crc_next;
	fst_conf_s  conf_reg;
	fst_conf_s  conf_next;
	fst_state_e state_reg;
	fst_state_e state_next;

	logic kick_cmd;
	logic reload_cmd;
	logic exit_cmd;

	always_comb begin
		kick_cmd   = wr_en && hit(paddr, IDX_CTRL) && pwdata[CTRL_KICK_BIT];
		reload_cmd = wr_en && hit(paddr, IDX_CTRL) && pwdata[CTRL_RELOAD_BIT];
		exit_cmd   = wr_en && hit(paddr, IDX_CTRL) && pwdata[CTRL_EXIT_BIT];
	end

	always_comb begin
		nv_timers_next = nv_timers_reg;
		nv_short_next  = nv_short_reg;
		nv_crc_next    = nv_crc_reg;
		conf_next      = conf_reg;
		if (wr_en && hit(paddr, IDX_WD_INIT)) begin
			nv_timers_next = pwdata[7:0];
		end
		if (wr_en && hit(paddr, IDX_SHORT_TH)) begin
			nv_short_next = pwdata[7:0];
		end
		if (wr_en && hit(paddr, IDX_CRC_REF)) begin
			nv_crc_next = pwdata[7:0];
		end
		if (state_reg == ST_LOAD) begin
			conf_next.wd_code   = nv_timers_reg[WD_CODE_LSB +: 4];
			conf_next.init_code = nv_timers_reg[INIT_CODE_LSB +: 4];
			conf_next.short_th  = nv_short_reg;
		end else begin
			if (wr_en && hit(paddr, IDX_CONF_TIMERS)) begin
				conf_next.wd_code   = pwdata[WD_CODE_LSB +: 4];
				conf_next.init_code = pwdata[INIT_CODE_LSB +: 4];
			end
			if (wr_en && hit(paddr, IDX_CONF_SHORT)) begin
				conf_next.short_th = pwdata[7:0];
			end
		end
	end

	// -------------------------------------------------------------------------
	// Sequencing
	// -------------------------------------------------------------------------
	logic        init_start;
	logic        wd_start;
	logic        wd_abort;
	logic        init_exp;
	logic        wd_exp;
	logic        crc_fault;
	logic        wd_timed;
	logic        wd_direct;
	logic [31:0] init_cycles;
	logic [31:0] wd_cycles;

	always_comb begin
		wd_timed    = conf_reg.wd_code != WD_DISABLED && conf_reg.wd_code < WD_DIRECT;
		wd_direct   = conf_reg.wd_code >= WD_DIRECT;
		init_cycles = 32'(init_time_us(conf_next.init_code) * CYCLES_PER_US);
		wd_cycles   = 32'(wd_time_us(conf_reg.wd_code) * CYCLES_PER_US);
	end

	always_comb begin
		state_next = state_reg;
		init_start = 1'b0;
		wd_start   = 1'b0;
		wd_abort   = 1'b0;
		case (state_reg)
			ST_LOAD: begin
				state_next = ST_INIT;
				init_start = 1'b1;
			end
			ST_INIT: begin
				if (init_exp) begin
					state_next = ST_NORMAL;
					wd_start   = wd_timed;
				end
			end
			ST_NORMAL: begin
				// No traffic needed with disabled or direct code: standalone parts sit here or fall to fail-safe
				if (wd_direct || wd_exp) begin
					state_next = ST_FAILSAFE;
					wd_abort   = 1'b1;
				end else if (kick_cmd || link_act) begin
					wd_start = wd_timed;
					wd_abort = !wd_timed;
				end else if (!wd_timed) begin
					wd_abort = 1'b1;
				end
			end
			ST_FAILSAFE: begin
				// Direct code keeps the device here even against an exit request
				if (exit_cmd && !wd_direct) begin
					state_next = ST_NORMAL;
					wd_start   = wd_timed;
				end
			end
			default: begin
				state_next = ST_LOAD;
			end
		endcase
		if (reload_cmd) begin
			state_next = ST_LOAD;
			wd_abort   = 1'b1;
			wd_start   = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nv_timers_reg <= WD_INIT_RESET;
			nv_short_reg  <= SHORT_TH_RESET;
			nv_crc_reg    <= CRC_REF_RESET;
			conf_reg      <= '0;
			state_reg     <= ST_LOAD;
		end else begin
			nv_timers_reg <= nv_timers_next;
			nv_short_reg  <= nv_short_next;
			nv_crc_reg    <= nv_crc_next;
			conf_reg      <= conf_next;
			state_reg     <= state_next;
		end
	end

	fst_timer u_init_timer (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (init_start),
		.abort    (reload_cmd),
		.load_val (init_cycles),
		.expired  (init_exp),
		.running  ()
	);

	fst_timer u_wd_timer (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (wd_start),
		.abort    (wd_abort),
		.load_val (wd_cycles),
		.expired  (wd_exp),
		.running  ()
	);

	fst_crc_check u_crc (
		.pclk      (pclk),
		.presetn   (presetn),
		.nv_timers (nv_timers_reg),
		.nv_short  (nv_short_reg),
		.nv_ref    (nv_crc_reg),
		.crc_fault (crc_fault)
	);

	// -------------------------------------------------------------------------
	// Read data and outputs
	// -------------------------------------------------------------------------
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;

	always_comb begin
		rdata_next = rdata_reg;
		if (rd_setup) begin
			rdata_next = '0;
			if (hit(paddr, IDX_WD_INIT)) begin
				rdata_next[7:0] = nv_timers_reg;
			end else if (hit(paddr, IDX_SHORT_TH)) begin
				rdata_next[7:0] = nv_short_reg;
			end else if (hit(paddr, IDX_CRC_REF)) begin
				rdata_next[7:0] = nv_crc_reg;
			end else if (hit(paddr, IDX_CONF_TIMERS)) begin
				rdata_next[7:0] = {conf_reg.wd_code, conf_reg.init_code};
			end else if (hit(paddr, IDX_CONF_SHORT)) begin
				rdata_next[7:0] = conf_reg.short_th;
			end else if (hit(paddr, IDX_STATUS)) begin
				rdata_next[STAT_FS_BIT]   = state_reg == ST_FAILSAFE;
				rdata_next[STAT_INIT_BIT] = state_reg == ST_NORMAL || state_reg == ST_FAILSAFE;
				rdata_next[STAT_CRC_BIT]  = crc_fault;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign prdata           = rdata_reg;
	assign conf             = conf_reg;
	assign status.failsafe  = state_reg == ST_FAILSAFE;
	assign status.init_done = state_reg == ST_NORMAL || state_reg == ST_FAILSAFE;
	assign status.crc_fault = crc_fault;

	// -------------------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_wd_disabled;
		state_reg == ST_NORMAL && conf_reg.wd_code == WD_DISABLED && !reload_cmd
			|=> state_reg == ST_NORMAL;
	endproperty
	a_wd_disabled: assert property (p_wd_disabled) else $error("disabled watchdog tripped");

	property p_direct;
		state_reg == ST_NORMAL && wd_direct && !reload_cmd |=> state_reg == ST_FAILSAFE;
	endproperty
	a_direct: assert property (p_direct) else $error("direct code did not enter fail-safe");

	sequence s_load_zero_init;
		state_reg == ST_LOAD && nv_timers_reg[INIT_CODE_LSB +: 4] == 4'h0 && !reload_cmd;
	endsequence
	property p_init_zero;
		s_load_zero_init ##1 !reload_cmd |=> state_reg == ST_NORMAL;
	endproperty
	a_init_zero: assert property (p_init_zero) else $error("zero init delay not honoured");

	property p_short_write;
		wr_en && hit(paddr, IDX_SHORT_TH) |=> nv_short_reg == $past(pwdata[7:0]);
	endproperty
	a_short_write: assert property (p_short_write) else $error("threshold write lost");

	property p_crc_write;
		wr_en && hit(paddr, IDX_CRC_REF) |=> nv_crc_reg == $past(pwdata[7:0]);
	endproperty
	a_crc_write: assert property (p_crc_write) else $error("crc reference write lost");

	property p_wd_trip;
		state_reg == ST_NORMAL && wd_exp && !reload_cmd |=> state_reg == ST_FAILSAFE;
	endproperty
	a_wd_trip: assert property (p_wd_trip) else $error("watchdog expiry ignored");

	property p_failsafe_hold;
		state_reg == ST_FAILSAFE && !exit_cmd && !reload_cmd |=> state_reg == ST_FAILSAFE;
	endproperty
	a_failsafe_hold: assert property (p_failsafe_hold) else $error("fail-safe left");

	property p_defaults;
		state_reg == ST_LOAD |=> conf_reg.short_th == $past(nv_short_reg) &&
			{conf_reg.wd_code, conf_reg.init_code} == $past(nv_timers_reg);
	endproperty
	a_defaults: assert property (p_defaults) else $error("defaults not loaded");

	property p_link_kick;
		state_reg == ST_NORMAL && link_act && wd_timed && !wd_exp && !reload_cmd |-> wd_start;
	endproperty
	a_link_kick: assert property (p_link_kick) else $error("link traffic did not kick");

endmodule : fst_failsafe_cfg

// *** fst_link_master.sv ***
// Behavioural master controller making traffic on the transceiver receive pin
`timescale 1ns/1ps
module fst_link_master #(
	parameter int GAP = 100 // Cycles between line edges
)(
	input  wire logic pclk,    // Bus clock
	input  wire logic presetn, // Async reset, active low
	input  wire logic talk,    // Controller alive and sending
	output logic      link_rx  // Receive pin, recessive high
);
	int cnt;

	// ------------------------------------------------------------------
	// Line driver
	// ------------------------------------------------------------------
	// A silent controller leaves the line recessive, as the pull-up does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt     <= 0;
			link_rx <= 1'b1;
		end else if (!talk) begin
			cnt     <= 0;
			link_rx <= 1'b1;
		end else if (cnt == GAP - 1) begin
			cnt     <= 0;
			link_rx <= ~link_rx;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : fst_link_master

// *** test_fst_failsafe_cfg.sv ***
// Self-checking bench of the fail-safe timer configuration block
`timescale 1ns/1ps
module test_fst_failsafe_cfg;
	import fst_pkg::*;
	localparam logic [7:0] REF_RST = 8'h3C; // Arbitrary value
	logic              pclk, presetn, psel, penable, pwrite, talk;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rdata;
	logic              pready, pslverr, rerr, link_rx;
	fst_conf_s         conf;
	fst_status_s       status;
	int                err_total, num_checks, n;
	int itime[16] = '{0, 50000, 20000, 10000, 5000, 2000, 1000, 500,
		200, 100, 50, 50, 50, 50, 50, 50};
	int wtime[6] = '{0, 200, 500, 1000, 2000, 5000};

	fst_failsafe_cfg #(.CYCLES_PER_US(1), .CRC_REF_RESET(REF_RST)) u_fst_failsafe_cfg (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link_rx(link_rx),
		.conf(conf), .status(status));
	fst_link_master #(.GAP(100)) u_fst_link_master (
		.pclk(pclk), .presetn(presetn), .talk(talk), .link_rx(link_rx));

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	task automatic rng(input int v, input int lo, input int hi, input string msg);
		check(32'(v >= lo && v <= hi), 32'h1, msg);
	endtask : rng

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rdata   = prdata;
		rerr    = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_total++;
			$display("mismatch at %0t: no bus answer", $time);
			report_and_stop();
		end
	endtask : apb

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string msg);
		apb(1'b0, a, 32'h0);
		check(rdata, exp, msg);
	endtask : rd

	task automatic tick(input int c);
		repeat (c) @(posedge pclk);
		#1;
	endtask : tick

	// Counts edges until a status flag is high; running out ends the run
	task automatic wait_stat(input int i, input int lim);
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (status[i] !== 1'b1 && n < lim);
		if (n >= lim) begin
			err_total++;
			$display("mismatch at %0t: status flag %0d never rose", $time, i);
			report_and_stop();
		end
	endtask : wait_stat

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic s_reset;
		tick(5);
		rd(12'h328, 32'h0, "timer byte reset");
		rd(12'h32C, 32'h0, "threshold reset");
		rd(12'h33C, {24'h0, REF_RST}, "crc ref reset");
		rd(12'h10C, 32'h6, "status after reset");
	endtask : s_reset

	// Bytes 00,00 give CRC 00; bytes 00,01 give CRC 07
	task automatic s_crc;
		wr(12'h33C, 32'hFFFF_FF81);
		rd(12'h33C, 32'h81, "crc ref write");
		wr(12'h33C, 32'h0);
		tick(3);
		check(status.crc_fault, 1'b0, "crc match");
		wr(12'h32C, 32'h1);
		tick(3);
		check(status.crc_fault, 1'b1, "crc mismatch");
		wr(12'h33C, 32'h7);
		tick(3);
		check(status.crc_fault, 1'b0, "crc of threshold");
		rd(12'h32C, 32'h1, "threshold write");
	endtask : s_crc

	task automatic s_unmapped;
		apb(1'b0, 12'h200, 32'h0);
		check(rerr, 1'b1, "unmapped read error");
		check(rdata, 32'h0, "unmapped read data");
		apb(1'b1, 12'h200, 32'hFF);
		check(rerr, 1'b1, "unmapped write");
		rd(12'h108, 32'h0, "control reads zero");
	endtask : s_unmapped

	task automatic s_default;
		wr(12'h328, 32'h39);
		wr(12'h32C, 32'hA5);
		tick(2);
		check(conf, 16'h0000, "working kept before reload");
		wr(12'h108, 32'h2);
		wait_stat(1, 200);
		check(conf, 16'h39A5, "defaults loaded");
		rd(12'h100, 32'h39, "working timers");
		talk <= 1'b1;
		tick(3000);
		check(status.failsafe, 1'b0, "traffic holds off");
		talk <= 1'b0;
		wait_stat(2, 1200);
		wr(12'h108, 32'h4);
		tick(2);
		check(status.failsafe, 1'b0, "exit fail-safe");
	endtask : s_default

	task automatic s_init;
		for (int c = 0; c < 16; c++) begin
			if (c inside {[2:5]})
				continue;
			wr(12'h328, 32'(c));
			wr(12'h108, 32'h2);
			wait_stat(1, itime[c] + 20);
			rng(n, itime[c], itime[c] + 8, "init delay");
		end
	endtask : s_init

	task automatic s_wd;
		for (int c = 1; c < 6; c++) begin
			wr(12'h328, 32'(c << 4));
			wr(12'h108, 32'h2);
			wait_stat(1, 20);
			wait_stat(2, wtime[c] + 20);
			rng(n, wtime[c] - 1, wtime[c] + 6, "watchdog delay");
		end
		wr(12'h328, 32'hC0);
		wr(12'h108, 32'h2);
		wait_stat(1, 20);
		wait_stat(2, 4);
		wr(12'h108, 32'h4);
		tick(3);
		check(status.failsafe, 1'b1, "exit refused");
		wr(12'h328, 32'h0);
		wr(12'h108, 32'h2);
		wait_stat(1, 20);
		tick(6000);
		check(status.failsafe, 1'b0, "disabled watchdog");
	endtask : s_wd

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	initial begin
		err_total  = 0;
		num_checks = 0;
		presetn    = 1'b0;
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = '0;
		pwdata     = '0;
		talk       = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		s_reset();
		s_crc();
		s_unmapped();
		s_default();
		s_init();
		s_wd();
		report_and_stop();
	end
endmodule : test_fst_failsafe_cfg
